// >>> hw/siovc_top.sv
// System I/O ports, video RAM arbitration and text pixel pipeline.
// Assumes async video RAM, async character ROM and CPU strobes on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module siovc_top
	import siovc_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire siovc_cpu_req_type cpu_req,
	output logic [7:0] cpu_rd_data,
	output logic cpu_rd_valid,
	output logic cpu_wait_n,
	output logic cpu_irq,
	input wire siovc_pins_type pins,
	input wire logic graphics_serial_pixels,
	input wire logic [10:0] crt_refresh_addr,
	input wire logic [3:0] crt_row,
	output logic refresh_advance,
	output logic [10:0] vram_addr,
	input wire logic [7:0] vram_rd_data,
	output logic [7:0] vram_wr_data,
	output logic vram_data_oe,
	output logic vram_we,
	output logic [12:0] char_rom_addr,
	input wire logic [7:0] char_rom_data,
	output logic video_out,
	output siovc_format_type screen_format,
	output logic [6:0] screen_cols,
	output logic [4:0] screen_rows,
	output siovc_ctrl_type ctrl,
	output logic [7:0] printer_data,
	output logic printer_strobe_n
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// low bits ignored
	function automatic logic port_hit(input logic [7:0] addr, input logic [7:0] base);
		port_hit = (addr[7:2] == base[7:2]);
	endfunction

	function automatic logic [11:0] format_size(input siovc_format_type f);
		case (f)
			FMT_64X16: format_size = {7'd64, 5'd16};
			FMT_32X16: format_size = {7'd32, 5'd16};
			FMT_80X24: format_size = {7'd80, 5'd24};
			default: format_size = {7'd40, 5'd24};
		endcase
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		siovc_pins_type s1;
		siovc_pins_type s2;
		siovc_pins_type s3;
		siovc_pins_type filt;
		logic [7:0] option;
		logic [7:0] sysctl;
		logic [6:0] int_en;
		logic sound;
		logic [1:0] cass_out;
		logic [7:0] prn_data;
		logic [7:0] strobe_cnt;
		logic rtc_div;
		logic rtc_pend;
		logic cass_rise;
		logic cass_fall;
		logic cass_latch;
		logic crt_phase;
		logic dot_phase;
		logic vram_pend;
		logic vram_write;
		logic vram_held;
		logic [10:0] cpu_vaddr;
		logic [10:0] vaddr;
		logic [7:0] vwdata;
		logic voe;
		logic vwe;
		logic [7:0] rdata;
		logic rvalid;
		logic [12:0] rom_addr;
		logic fetch_inv;
		logic fetch_ok;
		logic video;
	} siovc_state_type;
	siovc_state_type r_reg, r_next;

	localparam siovc_state_type STATE_RESET = '{option: OPTION_RESET, sysctl: SYSCTL_RESET, int_en: INTEN_RESET,
		default: '0};

	logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [8:0] fifo_out_data;
	logic pix, pix_inv, pix_valid;
	logic [6:0] int_status;
	logic [7:0] prn_status;
	logic [3:0] rom_row;
	logic vram_hit, text_bit, gfx_bit;
	logic [11:0] fmt_size;

	// ----------------------------------------
	// Combinational views
	// ----------------------------------------
	// status layout
	assign int_status = {r_reg.filt.rx_error, r_reg.filt.rx_data, r_reg.filt.tx_empty,
		~r_reg.filt.expansion_interrupt_line_n, r_reg.rtc_pend, r_reg.cass_fall, r_reg.cass_rise};
	assign prn_status = {r_reg.filt.prn_busy, r_reg.filt.prn_paper, r_reg.filt.prn_select,
		r_reg.filt.prn_fault, 4'h0};
	assign vram_hit = (cpu_req.addr[15:10] == MEM_VRAM_BASE[15:10]);
	assign rom_row = crt_row + (r_reg.filt.row_adjust_control ? 4'hf : 4'h0);
	assign screen_format = siovc_format_type'({r_reg.option[OPT_WIDE], r_reg.sysctl[SYS_DBLW]});
	assign fmt_size = format_size(screen_format);
	assign screen_cols = fmt_size[11:5];
	assign screen_rows = fmt_size[4:0];

	// Fetch stalls the CRT side while the FIFO is full
	assign refresh_advance = fifo_in_ready;
	assign cpu_wait_n = ~(r_reg.vram_pend || ((cpu_req.mem_rd || cpu_req.mem_wr) && vram_hit && !r_reg.vram_held));
	assign cpu_irq = |(int_status & r_reg.int_en);

	assign cpu_rd_data = r_reg.rdata;
	assign cpu_rd_valid = r_reg.rvalid;
	assign vram_addr = r_reg.vaddr;
	assign vram_wr_data = r_reg.vwdata;
	assign vram_data_oe = r_reg.voe;
	assign vram_we = r_reg.vwe;
	assign char_rom_addr = r_reg.rom_addr;
	assign video_out = r_reg.video;
	assign printer_data = r_reg.prn_data;
	assign printer_strobe_n = (r_reg.strobe_cnt == 8'h00);

	assign ctrl = '{
		fast_cpu_clock: r_reg.sysctl[SYS_FAST],
		external_io_enable: r_reg.sysctl[SYS_EXTIO],
		alternate_charset_enable: r_reg.sysctl[SYS_ALTSET],
		double_width_select: r_reg.sysctl[SYS_DBLW],
		cassette_motor: r_reg.sysctl[SYS_MOTOR],
		cassette_out: r_reg.cass_out,
		sound_out: r_reg.sound,
		video_page: r_reg.option[OPT_PAGE],
		memory_fixup: r_reg.option[OPT_FIXUP],
		memory_map: r_reg.option[OPT_MAP_LO +: 2],
		inverse_video_enable: r_reg.option[OPT_INVERSE],
		wide_select: r_reg.option[OPT_WIDE],
		select_bits: r_reg.option[OPT_SEL_LO +: 2]
	};

	assign text_bit = pix_valid && !r_reg.filt.text_output_inhibit && (pix ^ pix_inv);
	assign gfx_bit = r_reg.filt.graphics_data_enable && graphics_serial_pixels;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [7:0] code;
		logic inv, alt_slot;
		code = '0;
		inv = 1'b0;
		alt_slot = 1'b0;
		r_next = r_reg;
		// Pin inputs: three stages, accept when stages two and three agree
		r_next.s1 = pins;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		r_next.filt = (~(r_reg.s2 ^ r_reg.s3) & r_reg.s2) | ((r_reg.s2 ^ r_reg.s3) & r_reg.filt);
		r_next.rvalid = 1'b0;
		r_next.crt_phase = ~r_reg.crt_phase;
		r_next.dot_phase = ~r_reg.dot_phase;
		if (r_reg.strobe_cnt != 8'h00) begin
			r_next.strobe_cnt = r_reg.strobe_cnt - 8'h01;
		end

		// vsync divided by two unless fast
		// same fast bit picks the rate
		if (r_next.filt.vsync && !r_reg.filt.vsync) begin
			if (r_reg.sysctl[SYS_FAST]) begin
				r_next.rtc_pend = 1'b1;
			end else begin
				r_next.rtc_div = ~r_reg.rtc_div;
				if (r_reg.rtc_div) begin
					r_next.rtc_pend = 1'b1;
				end
			end
		end
		// read clears, a same-cycle tick wins
		if (cpu_req.io_rd && port_hit(cpu_req.addr[7:0], PORT_SYSCTL)
				&& !(r_next.filt.vsync && !r_reg.filt.vsync)) begin
			r_next.rtc_pend = 1'b0;
		end

		// write clears cassette latches before new edges land
		if (cpu_req.io_wr && port_hit(cpu_req.addr[7:0], PORT_CASSETTE)) begin
			r_next.cass_out = cpu_req.wdata[1:0];
			r_next.cass_latch = 1'b0;
			r_next.cass_rise = 1'b0;
			r_next.cass_fall = 1'b0;
		end
		if (r_next.filt.cassette_in && !r_reg.filt.cassette_in) begin
			r_next.cass_rise = 1'b1;
			r_next.cass_latch = 1'b1;
		end
		if (!r_next.filt.cassette_in && r_reg.filt.cassette_in) begin
			r_next.cass_fall = 1'b1;
		end

		// Port writes
		if (cpu_req.io_wr) begin
			if (port_hit(cpu_req.addr[7:0], PORT_OPTION)) begin
				r_next.option = cpu_req.wdata;
			end else if (port_hit(cpu_req.addr[7:0], PORT_SOUND)) begin
				r_next.sound = cpu_req.wdata[0];
			end else if (port_hit(cpu_req.addr[7:0], PORT_INT)) begin
				r_next.int_en = cpu_req.wdata[6:0];
			end else if (port_hit(cpu_req.addr[7:0], PORT_SYSCTL)) begin
				r_next.sysctl = cpu_req.wdata;
			end else if (port_hit(cpu_req.addr[7:0], PORT_PRINTER)) begin
				r_next.prn_data = cpu_req.wdata;
				r_next.strobe_cnt = STROBE_CYCLES;
			end
		end

		// Port reads answer one cycle later
		if (cpu_req.io_rd) begin
			r_next.rvalid = 1'b1;
			if (port_hit(cpu_req.addr[7:0], PORT_INT)) begin
				r_next.rdata = {1'b0, int_status};
			end else if (port_hit(cpu_req.addr[7:0], PORT_SYSCTL)) begin
				r_next.rdata = r_reg.sysctl;
			end else if (port_hit(cpu_req.addr[7:0], PORT_PRINTER)) begin
				r_next.rdata = prn_status;
			end else if (port_hit(cpu_req.addr[7:0], PORT_CASSETTE)) begin
				// 500 baud high, 1500 baud low
				r_next.rdata = {r_reg.cass_latch, 6'h00, r_reg.filt.cassette_in};
				r_next.rdata[CASS_HI_BIT] = r_reg.cass_latch;
			end else begin
				r_next.rdata = UNMAPPED_READ;
			end
		end else if (cpu_req.mem_rd && r_reg.option[OPT_MAP_LO +: 2] == MAP_COMPAT
				&& cpu_req.addr[15:1] == MEM_PRN_STATUS[15:1]) begin
			r_next.rvalid = 1'b1;
			r_next.rdata = prn_status;
		end

		// Video RAM request: one per held strobe, else a slow CPU would repeat it
		r_next.vram_held = (cpu_req.mem_rd || cpu_req.mem_wr) && vram_hit;
		if (!r_reg.vram_pend && !r_reg.vram_held && (cpu_req.mem_rd || cpu_req.mem_wr) && vram_hit) begin
			r_next.vram_pend = 1'b1;
			r_next.vram_write = cpu_req.mem_wr;
			r_next.cpu_vaddr = {r_reg.option[OPT_PAGE], cpu_req.addr[9:0]};
			r_next.vwdata = cpu_req.wdata;
		end

		// refresh on phase zero, CPU on phase one
		r_next.vaddr = r_next.crt_phase ? r_next.cpu_vaddr : crt_refresh_addr;
		// write buffer only in CPU phase
		r_next.vwe = r_next.crt_phase && r_next.vram_pend && r_next.vram_write;
		r_next.voe = r_next.vwe;
		if (r_reg.crt_phase && r_reg.vram_pend) begin
			r_next.vram_pend = 1'b0;
			if (!r_reg.vram_write) begin
				r_next.rdata = vram_rd_data;
				r_next.rvalid = 1'b1;
			end
		end

		// refresh data goes to the character path
		r_next.fetch_ok = 1'b0;
		if (!r_reg.crt_phase && fifo_in_ready) begin
			code = vram_rd_data;
			if (r_reg.option[OPT_INVERSE]) begin
				inv = code[7];
				code[7] = 1'b0;
				alt_slot = code[6];
			end else begin
				alt_slot = code[7] && code[6];
			end
			// alternate glyph bank for last 64 codes
			r_next.rom_addr = {r_reg.sysctl[SYS_ALTSET] && alt_slot, code, rom_row};
			r_next.fetch_inv = inv;
			r_next.fetch_ok = 1'b1;
		end

		r_next.video = (text_bit || gfx_bit)
			&& (r_reg.filt.dot_phase_select ? r_reg.dot_phase : ~r_reg.dot_phase);
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			r_reg <= STATE_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------
	// Glyph buffer and serializer
	// ----------------------------------------
	siovc_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.in_valid(r_reg.fetch_ok),
		.in_ready(fifo_in_ready),
		.in_data({r_reg.fetch_inv, char_rom_data}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// serial stream aligned to graphics pixels
	siovc_serializer u_ser (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.in_valid(fifo_out_valid),
		.in_ready(fifo_out_ready),
		.in_data(fifo_out_data),
		.pixel(pix),
		.pixel_inverse(pix_inv),
		.pixel_valid(pix_valid)
	);
endmodule
`default_nettype wire

// >>> hw/siovc_pkg.sv
// Package for the system I/O port and text video control block.
// Assumes a single 50 MHz clock and a byte-wide CPU port bus.
package siovc_pkg;
	// ----------------------------------------
	// Port and memory addresses
	// ----------------------------------------
	localparam logic [7:0] PORT_OPTION = 8'h84;
	localparam logic [7:0] PORT_SOUND = 8'h90;
	localparam logic [7:0] PORT_INT = 8'he0;
	localparam logic [7:0] PORT_SYSCTL = 8'hec;
	localparam logic [7:0] PORT_PRINTER = 8'hf8;
	localparam logic [7:0] PORT_CASSETTE = 8'hfc;
	localparam logic [15:0] MEM_PRN_STATUS = 16'h37e8;
	localparam logic [15:0] MEM_VRAM_BASE = 16'h3c00;
	localparam logic [7:0] UNMAPPED_READ = 8'hff;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SYS_FAST = 6;
	localparam int SYS_EXTIO = 4;
	localparam int SYS_ALTSET = 3;
	localparam int SYS_DBLW = 2;
	localparam int SYS_MOTOR = 1;
	localparam int OPT_PAGE = 7;
	localparam int OPT_FIXUP = 6;
	localparam int OPT_MAP_LO = 4;
	localparam int OPT_INVERSE = 3;
	localparam int OPT_WIDE = 2;
	localparam int OPT_SEL_LO = 0;
	localparam int CASS_HI_BIT = 7;
	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [7:0] OPTION_RESET = 8'h00;
	localparam logic [7:0] SYSCTL_RESET = 8'h00;
	localparam logic [6:0] INTEN_RESET = 7'h00;
	localparam logic [1:0] MAP_COMPAT = 2'h0;
	localparam int CLK_NS = 20;
	localparam int STROBE_NS = 1000;
	localparam logic [7:0] STROBE_CYCLES = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		FMT_64X16 = 2'b00,
		FMT_32X16 = 2'b01,
		FMT_80X24 = 2'b10,
		FMT_40X24 = 2'b11
	} siovc_format_type;
	typedef struct packed {
		logic io_rd;
		logic io_wr;
		logic mem_rd;
		logic mem_wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} siovc_cpu_req_type;
	typedef struct packed {
		logic vsync;
		logic cassette_in;
		logic expansion_interrupt_line_n;
		logic rx_error;
		logic rx_data;
		logic tx_empty;
		logic prn_busy;
		logic prn_paper;
		logic prn_select;
		logic prn_fault;
		logic row_adjust_control;
		logic text_output_inhibit;
		logic graphics_data_enable;
		logic dot_phase_select;
	} siovc_pins_type;
	typedef struct packed {
		logic fast_cpu_clock;
		logic external_io_enable;
		logic alternate_charset_enable;
		logic double_width_select;
		logic cassette_motor;
		logic [1:0] cassette_out;
		logic sound_out;
		logic video_page;
		logic memory_fixup;
		logic [1:0] memory_map;
		logic inverse_video_enable;
		logic wide_select;
		logic [1:0] select_bits;
	} siovc_ctrl_type;
endpackage

// >>> hw/siovc_fifo.sv
// Glyph FIFO between character fetch and the pixel serializer.
// Assumes both sides on ref_clk; push and pop are valid/ready.
`timescale 1ns/1ps
`default_nettype none
module siovc_fifo
	import siovc_pkg::*;
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	typedef struct packed {
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [CW-1:0] count;
	} siovc_fifo_state_type;
	siovc_fifo_state_type r_reg, r_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	assign in_ready = (r_reg.count != CW'(DEPTH));
	assign out_valid = (r_reg.count != '0);
	assign out_data = mem[r_reg.rptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		r_next = r_reg;
		if (push) begin
			r_next.wptr = (r_reg.wptr == AW'(DEPTH - 1)) ? '0 : r_reg.wptr + 1'b1;
		end
		if (pop) begin
			r_next.rptr = (r_reg.rptr == AW'(DEPTH - 1)) ? '0 : r_reg.rptr + 1'b1;
		end
		if (push && !pop) begin
			r_next.count = r_reg.count + 1'b1;
		end else if (pop && !push) begin
			r_next.count = r_reg.count - 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[r_reg.wptr] <= in_data;
		end
	end
endmodule
`default_nettype wire

// >>> hw/siovc_serializer.sv
// Shifts one glyph row out, MSB first, one pixel per clock.
// Assumes words arrive as {inverse flag, 8 glyph bits}.
`timescale 1ns/1ps
`default_nettype none
module siovc_serializer
	import siovc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [8:0] in_data,
	output logic pixel,
	output logic pixel_inverse,
	output logic pixel_valid
);
	typedef struct packed {
		logic [7:0] shift;
		logic inv;
		logic [3:0] left;
	} siovc_ser_state_type;
	siovc_ser_state_type r_reg, r_next;

	// Reload on the last bit so rows run back to back without a gap
	assign in_ready = (r_reg.left <= 4'h1);
	assign pixel = r_reg.shift[7];
	assign pixel_inverse = r_reg.inv;
	assign pixel_valid = (r_reg.left != 4'h0);

	always_comb begin
		r_next = r_reg;
		if (in_valid && in_ready) begin
			r_next.shift = in_data[7:0];
			r_next.inv = in_data[8];
			r_next.left = 4'h8;
		end else if (r_reg.left != 4'h0) begin
			r_next.shift = {r_reg.shift[6:0], 1'b0};
			r_next.left = r_reg.left - 4'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end
endmodule
`default_nettype wire

// >>> sim/siovc_checker.sv
// Port-level assertions for the I/O port and video block.
// Assumes one clock domain; bound to siovc_top at the foot.
`timescale 1ns/1ps
`default_nettype none
module siovc_checker
	import siovc_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire siovc_cpu_req_type cpu_req,
	input wire logic cpu_rd_valid,
	input wire logic cpu_wait_n,
	input wire logic vram_we,
	input wire logic vram_data_oe,
	input wire siovc_format_type screen_format,
	input wire logic [6:0] screen_cols,
	input wire logic [4:0] screen_rows,
	input wire siovc_ctrl_type ctrl,
	input wire logic [7:0] printer_data,
	input wire logic printer_strobe_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic [5:0] port;
	assign port = cpu_req.addr[7:2];
	// ----------------------------------------
	// Sequences and properties
	// ----------------------------------------
	sequence s_wr(p);
		cpu_req.io_wr && port == p;
	endsequence
	sequence s_vreq;
		$rose(cpu_req.mem_wr) && cpu_req.addr[15:10] == MEM_VRAM_BASE[15:10];
	endsequence
	property p_prn_data;
		s_wr(PORT_PRINTER[7:2]) |=> printer_data == $past(cpu_req.wdata);
	endproperty
	property p_strobe;
		s_wr(PORT_PRINTER[7:2]) |=> !printer_strobe_n [*8];
	endproperty
	property p_sysctl;
		logic [7:0] v;
		(s_wr(PORT_SYSCTL[7:2]), v = cpu_req.wdata) |=> {ctrl.fast_cpu_clock, ctrl.external_io_enable,
			ctrl.alternate_charset_enable, ctrl.double_width_select, ctrl.cassette_motor} == {v[6], v[4:1]};
	endproperty
	property p_option;
		logic [7:0] v;
		(s_wr(PORT_OPTION[7:2]), v = cpu_req.wdata) |=> {ctrl.video_page, ctrl.memory_fixup, ctrl.memory_map,
			ctrl.inverse_video_enable, ctrl.wide_select, ctrl.select_bits} == v;
	endproperty
	property p_cass;
		logic [7:0] v;
		(s_wr(PORT_CASSETTE[7:2]), v = cpu_req.wdata) |=> ctrl.cassette_out == v[1:0];
	endproperty
	property p_format;
		screen_format == {ctrl.wide_select, ctrl.double_width_select}
			&& screen_rows == (ctrl.wide_select ? 5'h18 : 5'h10)
			&& screen_cols == ((ctrl.wide_select ? 7'h50 : 7'h40) >> ctrl.double_width_select);
	endproperty
	property p_rd_ans;
		cpu_req.io_rd |=> cpu_rd_valid;
	endproperty
	property p_memprn;
		cpu_req.mem_rd && cpu_req.addr[15:1] == MEM_PRN_STATUS[15:1] && ctrl.memory_map == MAP_COMPAT
			|=> cpu_rd_valid;
	endproperty
	property p_vram_we;
		vram_we |-> vram_data_oe ##1 !vram_we;
	endproperty
	property p_wait;
		s_vreq |-> !cpu_wait_n ##[1:4] cpu_wait_n;
	endproperty
	property p_vwrite;
		s_vreq |-> ##[1:4] vram_we;
	endproperty
	a_prn_data: assert property (p_prn_data) else $error("printer data not latched");
	a_strobe: assert property (p_strobe) else $error("printer strobe too short");
	a_sysctl: assert property (p_sysctl) else $error("system control bits wrong");
	a_option: assert property (p_option) else $error("option bits wrong");
	a_cass: assert property (p_cass) else $error("cassette output wrong");
	a_format: assert property (p_format) else $error("screen format wrong");
	a_rd_ans: assert property (p_rd_ans) else $error("port read not answered");
	a_memprn: assert property (p_memprn) else $error("status memory read not answered");
	a_vram_we: assert property (p_vram_we) else $error("video write not driven");
	a_wait: assert property (p_wait) else $error("video wait not bounded");
	a_vwrite: assert property (p_vwrite) else $error("video write missing");
endmodule
bind siovc_top siovc_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_siovc_checker (.ref_clk, .reset_n, .cpu_req,
	.cpu_rd_valid, .cpu_wait_n, .vram_we, .vram_data_oe, .screen_format, .screen_cols, .screen_rows, .ctrl,
	.printer_data, .printer_strobe_n);
`default_nettype wire

// >>> sim/siovc_mem_model.sv
// Video RAM and character ROM seen from the block's far side.
// Assumes async reads and a write on the edge after vram_we.
`timescale 1ns/1ps
`default_nettype none
module siovc_mem_model
	import siovc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [10:0] vram_addr,
	input wire logic [7:0] vram_wr_data,
	input wire logic vram_data_oe,
	input wire logic vram_we,
	output logic [7:0] vram_rd_data,
	input wire logic [12:0] char_rom_addr,
	output logic [7:0] char_rom_data
);
	logic [7:0] mem [2048];
	initial begin
		for (int i = 0; i < 2048; i++) begin
			mem[i] = 8'hc1;
		end
	end
	always @(posedge ref_clk) begin
		if (vram_we) begin
			mem[vram_addr] <= vram_wr_data;
		end
	end
	// RAM output off; flip so stale data shows
	assign vram_rd_data = vram_data_oe ? ~mem[vram_addr] : mem[vram_addr];
	assign char_rom_data = char_rom_addr[11:4] ^ {char_rom_addr[3:0], 4'h5};
endmodule
`default_nettype wire

// >>> sim/siovc_bench.sv
// Self-checking bench for the I/O port and video block.
// Assumes 50 MHz ref_clk and inputs changed 2 ns after edges.
`timescale 1ns/1ps
`default_nettype none
module siovc_bench
	import siovc_pkg::*;
;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	siovc_cpu_req_type cpu_req = '0;
	siovc_pins_type pins = '0;
	logic gfx_pix = 1'b0;
	logic [7:0] cpu_rd_data, vram_rd_data, vram_wr_data, char_rom_data, printer_data;
	logic cpu_rd_valid, cpu_wait_n, cpu_irq, vram_data_oe, vram_we, video_out, printer_strobe_n, refresh_advance;
	logic [10:0] vram_addr;
	logic [12:0] char_rom_addr;
	logic [6:0] screen_cols;
	logic [4:0] screen_rows;
	siovc_format_type screen_format;
	siovc_ctrl_type ctrl;
	int errors = 0;
	int checks_done = 0;
	logic [31:0] rows [7] = '{32'hec5eec5e, 32'hefffedff, 32'he000e050, 32'hf83cf8a0, 32'hfc03fc00, 32'h84a584ff,
		32'h900193ff};
	logic [31:0] glyph [4] = '{32'h0808141f, 32'h00081c1f, 32'h00000c1f, 32'h0800041f};
	logic [7:0] cols [4] = '{8'h40, 8'h20, 8'h50, 8'h28};
	logic [7:0] lines [4] = '{8'h10, 8'h10, 8'h18, 8'h18};
	always #10 ref_clk = ~ref_clk;
	siovc_top #(.FIFO_DEPTH(16)) u_siovc_top (.ref_clk(ref_clk), .reset_n(reset_n), .cpu_req(cpu_req),
		.cpu_rd_data(cpu_rd_data), .cpu_rd_valid(cpu_rd_valid), .cpu_wait_n(cpu_wait_n), .cpu_irq(cpu_irq),
		.pins(pins), .graphics_serial_pixels(gfx_pix), .crt_refresh_addr(11'h100), .crt_row(4'h0),
		.refresh_advance(refresh_advance), .vram_addr(vram_addr), .vram_rd_data(vram_rd_data),
		.vram_wr_data(vram_wr_data),
		.vram_data_oe(vram_data_oe), .vram_we(vram_we), .char_rom_addr(char_rom_addr),
		.char_rom_data(char_rom_data), .video_out(video_out), .screen_format(screen_format),
		.screen_cols(screen_cols), .screen_rows(screen_rows), .ctrl(ctrl), .printer_data(printer_data),
		.printer_strobe_n(printer_strobe_n));
	siovc_mem_model u_siovc_mem_model (.ref_clk(ref_clk), .vram_addr(vram_addr), .vram_wr_data(vram_wr_data),
		.vram_data_oe(vram_data_oe), .vram_we(vram_we), .vram_rd_data(vram_rd_data),
		.char_rom_addr(char_rom_addr), .char_rom_data(char_rom_data));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic end_of_test();
		if (errors == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cpu_req.io_wr = 1'b1;
		cpu_req.addr = {8'h00, a};
		cpu_req.wdata = d;
		tick(1);
		cpu_req.io_wr = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		cpu_req.io_rd = 1'b1;
		cpu_req.addr = {8'h00, a};
		tick(1);
		cpu_req.io_rd = 1'b0;
		chk(16'(cpu_rd_valid), 16'h1);
		d = cpu_rd_data;
		tick(1);
	endtask
	// Strobe held until wait releases; only the first edge is taken
	task automatic vm(input logic w, input logic [7:0] d, output logic [7:0] q);
		int n;
		logic got;
		n = 0;
		got = 1'b0;
		q = 8'h00;
		cpu_req = '{io_rd: 1'b0, io_wr: 1'b0, mem_rd: !w, mem_wr: w, addr: 16'h3c05, wdata: d};
		do begin
			tick(1);
			n++;
			if (cpu_rd_valid === 1'b1) begin
				got = 1'b1;
				q = cpu_rd_data;
			end
		end while (n < 10 && !(cpu_wait_n === 1'b1 && (w || got)));
		cpu_req.mem_rd = 1'b0;
		cpu_req.mem_wr = 1'b0;
		tick(1);
		if (n >= 10) begin
			errors++;
			end_of_test();
		end
	endtask
	task automatic vpulse();
		pins.vsync = 1'b1;
		tick(6);
		pins.vsync = 1'b0;
		tick(6);
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		logic [7:0] d;
		int n;
		pins.expansion_interrupt_line_n = 1'b1;
		pins.rx_error = 1'b1;
		pins.tx_empty = 1'b1;
		pins.prn_busy = 1'b1;
		pins.prn_select = 1'b1;
		pins.text_output_inhibit = 1'b1;
		tick(5);
		chk(ctrl, 16'h0000);
		chk({cpu_irq, vram_we, cpu_rd_valid, printer_strobe_n, refresh_advance, video_out}, 16'h6);
		reset_n = 1'b1;
		tick(6);
		foreach (rows[i]) begin
			wr(rows[i][31:24], rows[i][23:16]);
			rd(rows[i][15:8], d);
			chk(d, rows[i][7:0]);
		end
		chk({ctrl.video_page, ctrl.memory_fixup, ctrl.memory_map, ctrl.inverse_video_enable, ctrl.wide_select,
			ctrl.select_bits}, 16'ha5);
		pins.prn_busy = 1'b0;
		tick(6);
		rd(PORT_PRINTER, d);
		chk(d, 16'h20);
		wr(PORT_PRINTER, 8'h5a);
		chk(printer_data, 16'h5a);
		n = 0;
		while (printer_strobe_n === 1'b0 && n < 60) begin
			n++;
			tick(1);
		end
		// Write helper returns one edge into the pulse
		chk(16'(n), 16'(STROBE_CYCLES) - 16'h1);
		for (int i = 0; i < 4; i++) begin
			wr(PORT_OPTION, {5'h00, i[1], 2'h0});
			wr(PORT_SYSCTL, {5'h00, i[0], 2'h0});
			chk({screen_format, screen_cols, screen_rows}, {2'(i), cols[i][6:0], lines[i][4:0]});
		end
		// Expansion line readable while masked
		pins.expansion_interrupt_line_n = 1'b0;
		tick(6);
		rd(PORT_INT, d);
		chk({d[3], cpu_irq}, 16'h2);
		wr(PORT_INT, 8'h08);
		chk(cpu_irq, 16'h1);
		wr(PORT_INT, 8'h00);
		chk(cpu_irq, 16'h0);
		pins.expansion_interrupt_line_n = 1'b1;
		wr(PORT_SYSCTL, 8'h40);
		rd(PORT_SYSCTL, d);
		vpulse();
		rd(PORT_INT, d);
		chk(d[2], 16'h1);
		rd(PORT_SYSCTL, d);
		rd(PORT_INT, d);
		chk(d[2], 16'h0);
		wr(PORT_SYSCTL, 8'h00);
		n = 0;
		repeat (2) begin
			vpulse();
			rd(PORT_INT, d);
			n += int'(d[2]);
			rd(PORT_SYSCTL, d);
		end
		chk(16'(n), 16'h1);
		pins.cassette_in = 1'b1;
		tick(6);
		rd(PORT_CASSETTE, d);
		chk(d, 16'h81);
		rd(PORT_INT, d);
		chk(d[1:0], 16'h1);
		wr(PORT_CASSETTE, 8'h02);
		chk(ctrl.cassette_out, 16'h2);
		rd(PORT_CASSETTE, d);
		chk(d, 16'h01);
		rd(PORT_INT, d);
		chk(d[1:0], 16'h0);
		for (int m = 0; m < 2; m++) begin
			wr(PORT_OPTION, m[0] ? 8'h20 : 8'h00);
			cpu_req.mem_rd = 1'b1;
			cpu_req.addr = 16'h37e9;
			tick(1);
			cpu_req.mem_rd = 1'b0;
			chk({cpu_rd_valid, cpu_rd_data}, m[0] ? 16'h020 : 16'h120);
			tick(1);
		end
		vm(1'b1, 8'h77, d);
		vm(1'b0, 8'h00, d);
		chk(d, 16'h77);
		pins.row_adjust_control = 1'b1;
		foreach (glyph[i]) begin
			wr(PORT_OPTION, glyph[i][31:24]);
			wr(PORT_SYSCTL, glyph[i][23:16]);
			tick(20);
			chk(char_rom_addr, glyph[i][15:0]);
		end
		pins.row_adjust_control = 1'b0;
		tick(20);
		chk(char_rom_addr[3:0], 16'h0);
		for (int g = 0; g < 3; g++) begin
			pins.graphics_data_enable = g[0];
			pins.text_output_inhibit = (g < 2);
			pins.dot_phase_select = g[1];
			gfx_pix = g[0];
			tick(6);
			n = 0;
			repeat (40) begin
				tick(1);
				n += int'(video_out);
			end
			chk(16'(n != 0), 16'(g != 0));
		end
		end_of_test();
	end
endmodule
`default_nettype wire
